// *** rtl/ddc_ctl.sv ***
/*
  ddr2 controller end: takes orders through a small register port, spaces
  commands per bank and globally, posts refresh, runs the termination
  update and self refresh sequences on the command pins.
  assumes sys_clk keeps running; stopping the memory clock is outside.
*/
// Design decisions made here: the strobed register port and the register addresses.
// Contract
// [RL1] wait termination off delay before termination update
// [RL2] hold termination low through update window
// [RL3] activate bank before read or write
// [RL4] additive latency 0..6 posts column commands
// [RL5] precharge before reactivation; keep row spacing
// [RL6] at most four activates per window
// [RL7] precharge all waits one extra clock
// [RL8] read: bank, column bits, auto close
// [RL9] write likewise; row stays open otherwise
// [RL10] read auto close after AL plus BL/2
// [RL11] write auto close after burst plus recovery
// [RL12] precharge all closes every bank
// [RL13] termination off before self refresh; hold cke
// [RL14] self refresh: internal timer, dll off
// [RL15] clock may stop after entry registered
// [RL16] only nop during exit interval
// [RL17] keep cke high, termination off, after exit
// [RL18] one refresh before self refresh re-entry
// [RL19] refresh row internal; banks end idle
// [RL20] refresh cycle time before activate or refresh
// [RL21] refresh averages interval; eight may be postponed
// [RL22] write latency is read latency minus one
// [RL23] nop does nothing
// [RL24] track eight bank states for legal commands
`timescale 1ns/1ps
module ddc_ctl (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  ddc_if.ctl               mem
);
  import ddc_pkg::*;

  ddc_pkg::ddc_st_t st_r;
  logic            pend_r;
  logic [3:0]      op_r;
  logic [2:0]      ba_r;
  logic            ac_r;
  logic [13:0]     ad_r;
  logic            odt_en_r;
  logic            err_r;
  logic            need_ref_r;
  logic [3:0]      owed_r;
  logic [CW-1:0]   refi_r;
  logic [CW-1:0]   wait_r;
  logic [CW-1:0]   rfc_r;
  logic [CW-1:0]   rrd_r;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   xsrd_r;
  logic [2:0]      odt_lo_r;
  logic [7:0]      open_r;
  logic [FAW_HIST-1:0] hist_r;
  logic [7:0]      rc_ok;

  function automatic logic [7:0] bank_hot(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  wire run     = st_r == ST_RUN;
  wire idle    = open_r == 8'h00;
  wire quiet   = wait_r == '0 && rfc_r == '0;
  wire odt_off = odt_lo_r == 3'(AOFD_CK);
  wire faw_ok  = $countones(hist_r) < 4;
  wire b_open  = open_r[ba_r];
  wire is_rw   = op_r == OP_RD || op_r == OP_WR;
  wire bad     = pend_r && ((op_r == OP_ACT && b_open) || (is_rw && !b_open)
                 || (op_r == OP_SRX && st_r != ST_SREF)); // see [RL24]
  wire ref_max = owed_r == 4'(POST_MAX);
  wire auto_go = run && owed_r != 4'h0 && (ref_max || !pend_r) && quiet;
  wire [3:0] go_op = auto_go ? (idle ? OP_REF : OP_PREA) : op_r;
  wire go_rw   = go_op == OP_RD || go_op == OP_WR;
  wire ap_bit  = go_rw ? ac_r : (go_op != OP_PRE) && ad_r[A_ACLR];

  logic ok;
  always_comb begin
    case (op_r)
      OP_ACT:  ok = run && !b_open && rc_ok[ba_r] && rrd_r == '0 && faw_ok && quiet;
      OP_RD,
      OP_WR:   ok = run && b_open && wait_r == '0; // see [RL3]
      OP_PRE,
      OP_PREA: ok = run && wait_r == '0;
      OP_REF:  ok = run && idle && quiet; // see [RL20]
      OP_SRE:  ok = run && idle && quiet && !need_ref_r && odt_off; // see [RL13] see [RL18]
      OP_SRX:  ok = st_r == ST_SREF && cnt_r == '0;
      OP_EMRS: ok = run && idle && wait_r == '0 && odt_off; // see [RL1]
      default: ok = 1'b0;
    endcase
  end
  wire user_go = pend_r && !auto_go && !bad && ok;
  wire go      = auto_go || user_go;
  wire odt_nxt = odt_en_r && run && xsrd_r == '0 && !need_ref_r
                 && !(pend_r && (op_r == OP_SRE || op_r == OP_EMRS)); // see [RL2] see [RL17]

  // per bank row cycle spacing
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rc
      logic [CW-1:0] rc_r;
      assign rc_ok[g] = rc_r == '0;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) rc_r <= '0;
        else if (clk_en) begin
          if (go && ba_r == 3'(g) && !auto_go && go_op == OP_ACT) rc_r <= CW'(RC_CK - 1);
          else if (go && ba_r == 3'(g) && !auto_go && is_rw && ac_r) rc_r <= CW'(AP_HOLD_CK);
          else if (rc_r != '0) rc_r <= rc_r - 1'b1; // see [RL5]
        end
      end
    end
  endgenerate

  wire [31:0] stat = {11'h000, st_r, 1'b0, open_r, owed_r, need_ref_r, err_r,
                      st_r == ST_SREF, pend_r};
  wire [31:0] rd_mux = (reg_addr == REG_CMD)  ? {10'h000, ad_r, ac_r, ba_r, op_r} :
                       (reg_addr == REG_CFG)  ? {31'h0000_0000, odt_en_r} :
                       (reg_addr == REG_STAT) ? stat : 32'h0000_0000;
  wire take = reg_wr && reg_addr == REG_CMD;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      pend_r    <= 1'b0;
      op_r      <= 4'h0;
      ba_r      <= 3'h0;
      ac_r      <= 1'b0;
      ad_r      <= 14'h0000;
      odt_en_r  <= 1'b0;
      err_r     <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && reg_addr == REG_CFG) odt_en_r <= reg_wdata[0];
      if (take && !pend_r) begin
        pend_r <= 1'b1;
        op_r   <= reg_wdata[F_OP+3:F_OP];
        ba_r   <= reg_wdata[F_BA+2:F_BA];
        ac_r   <= reg_wdata[F_AC];
        ad_r   <= reg_wdata[F_AD+13:F_AD];
      end else if (user_go || bad) pend_r <= 1'b0;
      if (bad || (take && pend_r)) err_r <= 1'b1;
      else if (reg_rd && reg_addr == REG_STAT) err_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP;
      mem.cke  <= 1'b0;
      mem.odt  <= 1'b0;
      mem.ba   <= 3'h0;
      mem.addr <= 14'h0000;
    end else if (clk_en) begin
      mem.odt  <= odt_nxt;
      mem.ba   <= (go_op == OP_EMRS) ? BA_EMR1 : ba_r;
      mem.addr <= (go_op == OP_PREA) ? 14'h0400 : {ad_r[13:11], ap_bit, ad_r[9:0]}; // see [RL8]
      mem.cke  <= st_r != ST_SREF || (go && go_op == OP_SRX); // see [RL13]
      if (go && go_op == OP_SRE) mem.cke <= 1'b0;
      if (!go) {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP; // see [RL16]
      else begin
        case (go_op)
          OP_ACT:  {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_ACT;
          OP_RD:   {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_RD;
          OP_WR:   {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_WR; // see [RL9]
          OP_PRE,
          OP_PREA: {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_PRE;
          OP_REF,
          OP_SRE:  {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_REF;
          OP_EMRS: {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_MRS;
          default: {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} <= CMD_NOP;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= ST_RUN;
      cnt_r      <= '0;
      wait_r     <= '0;
      rfc_r      <= '0;
      rrd_r      <= '0;
      xsrd_r     <= '0;
      open_r     <= 8'h00;
      hist_r     <= '0;
      need_ref_r <= 1'b0;
      odt_lo_r   <= 3'h0;
    end else if (clk_en) begin
      if (cnt_r != '0) cnt_r <= cnt_r - 1'b1;
      if (wait_r != '0) wait_r <= wait_r - 1'b1;
      if (rfc_r != '0) rfc_r <= rfc_r - 1'b1;
      if (rrd_r != '0) rrd_r <= rrd_r - 1'b1;
      if (xsrd_r != '0) xsrd_r <= xsrd_r - 1'b1;
      if (mem.odt) odt_lo_r <= 3'h0;
      else if (!odt_off) odt_lo_r <= odt_lo_r + 3'h1;
      hist_r <= FAW_HIST'({hist_r, go && go_op == OP_ACT}); // see [RL6]
      if ((st_r == ST_MOD || st_r == ST_XSNR) && cnt_r == '0) st_r <= ST_RUN;
      if (go) begin
        case (go_op)
          OP_ACT: begin
            open_r <= open_r | bank_hot(ba_r);
            rrd_r  <= CW'(RRD_CK - 1); // see [RL5]
          end
          OP_RD, OP_WR: begin
            wait_r <= CW'(CCD_CK - 1);
            if (ac_r) open_r <= open_r & ~bank_hot(ba_r); // see [RL10] see [RL11]
          end
          OP_PRE: begin
            open_r <= open_r & ~bank_hot(ba_r);
            wait_r <= CW'(RP_CK - 1);
          end
          OP_PREA: begin
            open_r <= 8'h00; // see [RL12]
            wait_r <= CW'(PREA_CK - 1); // see [RL7]
          end
          OP_REF: begin
            rfc_r      <= CW'(RFC_CK - 1); // see [RL19]
            need_ref_r <= 1'b0;
          end
          OP_SRE: begin
            st_r  <= ST_SREF; // see [RL14] see [RL15]
            cnt_r <= CW'(CKE_MIN_CK - 1);
          end
          OP_SRX: begin
            st_r       <= ST_XSNR;
            cnt_r      <= CW'(XSNR_CK - 1);
            xsrd_r     <= CW'(XSRD_CK - 1);
            need_ref_r <= 1'b1;
          end
          OP_EMRS: begin
            st_r  <= ST_MOD;
            cnt_r <= CW'(MOD_CK - 1);
          end
          default: st_r <= st_r;
        endcase
      end
    end
  end

  // refresh posting: one owed per interval, forced once eight are owed
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refi_r <= CW'(REFI_CK - 1);
      owed_r <= 4'h0;
    end else if (clk_en) begin
      if (st_r == ST_SREF) begin
        refi_r <= CW'(REFI_CK - 1);
        owed_r <= 4'h0;
      end else begin
        refi_r <= (refi_r == '0) ? CW'(REFI_CK - 1) : refi_r - 1'b1;
        if (refi_r == '0 && !(go && go_op == OP_REF)) owed_r <= owed_r + 4'h1; // see [RL21]
        else if (refi_r != '0 && go && go_op == OP_REF && owed_r != 4'h0)
          owed_r <= owed_r - 4'h1;
      end
    end
  end
endmodule // ddc_ctl

// *** rtl/ddc_pkg.sv ***
/*
  shared constants for the ddr2 command end pair: pin encodings, timing
  counts at the 40 MHz system clock, controller op codes and register map.
  assumes both ends run on one clock, sys_clk.
*/
package ddc_pkg;
  localparam int CLK_PS = 25000;

  function automatic int ck_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int ck_dn(input int ns);
    int c;
    c = (ns * 1000) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // times in ns as printed for the timing grade
  localparam int T_RC_NS    = 55;
  localparam int T_RRD_NS   = 10;
  localparam int T_FAW_NS   = 45;
  localparam int T_RP_NS    = 15;
  localparam int T_RFC_NS   = 128;
  localparam int T_XSNR_NS  = 138;
  localparam int T_MOD_NS   = 12;
  localparam int T_WR_NS    = 15;
  localparam int T_REFI_NS  = 7800;

  localparam int RC_CK      = ck_up(T_RC_NS);
  localparam int RRD_CK     = ck_up(T_RRD_NS);
  localparam int FAW_CK     = ck_up(T_FAW_NS);
  localparam int RP_CK      = ck_up(T_RP_NS);
  localparam int PREA_CK    = RP_CK + 1;
  localparam int RFC_CK     = ck_up(T_RFC_NS);
  localparam int XSNR_CK    = ck_up(T_XSNR_NS);
  localparam int MOD_CK     = ck_up(T_MOD_NS);
  localparam int WR_CK      = ck_up(T_WR_NS);
  localparam int REFI_CK    = ck_dn(T_REFI_NS);
  localparam int AOFD_CK    = 3;
  localparam int XSRD_CK    = 200;
  localparam int CCD_CK     = 2;
  localparam int CKE_MIN_CK = 3;
  localparam int AL_MAX     = 6;
  localparam int POST_MAX   = 8;
  localparam int AP_HOLD_CK = AL_MAX + 4 + WR_CK + RP_CK;
  localparam int FAW_HIST   = (FAW_CK > 2) ? FAW_CK - 1 : 1;
  localparam int CW         = 9;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam int         A_ACLR  = 10;

  localparam logic [3:0] OP_ACT  = 4'h1;
  localparam logic [3:0] OP_RD   = 4'h2;
  localparam logic [3:0] OP_WR   = 4'h3;
  localparam logic [3:0] OP_PRE  = 4'h4;
  localparam logic [3:0] OP_PREA = 4'h5;
  localparam logic [3:0] OP_REF  = 4'h6;
  localparam logic [3:0] OP_SRE  = 4'h7;
  localparam logic [3:0] OP_SRX  = 4'h8;
  localparam logic [3:0] OP_EMRS = 4'h9;

  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_CFG  = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int F_OP = 0;
  localparam int F_BA = 4;
  localparam int F_AC = 7;
  localparam int F_AD = 8;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_MOD  = 4'b0010,
    ST_SREF = 4'b0100,
    ST_XSNR = 4'b1000
  } ddc_st_t;
endpackage

// *** rtl/ddc_if.sv ***
/*
  command and address pins between controller and ddr2 device.
  assumes the bench joins both modports on one sys_clk.
*/
`timescale 1ns/1ps
interface ddc_if (
  input wire logic sys_clk
);
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        odt;
  logic [2:0]  ba;
  logic [13:0] addr;

  modport ctl (input sys_clk, output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
  modport dev (input sys_clk, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface

// *** rtl/ddc_dev.sv ***
/*
  ddr2 device end: decodes commands, tracks banks, posts column commands,
  runs auto close of rows and refresh row counting.
  assumes mode settings arrive as static cfg inputs.
*/
`timescale 1ns/1ps
module ddc_dev (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  ddc_if.dev              mem,
  input  wire logic [2:0] cfg_al,
  input  wire logic [2:0] cfg_cl,
  input  wire logic       cfg_bl8,
  input  wire logic [2:0] cfg_wr,
  output logic [7:0]      bank_open,
  output logic            self_ref,
  output logic            dll_on,
  output logic            col_rd,
  output logic            col_wr,
  output logic [2:0]      col_bank,
  output logic [9:0]      col_addr,
  output logic [3:0]      rd_lat,
  output logic [3:0]      wr_lat,
  output logic [13:0]     ref_row,
  output logic            cmd_err
);
  import ddc_pkg::*;

  function automatic logic [7:0] bank_hot(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  logic            cke_q_r;
  logic [14:0]     pipe_r [0:AL_MAX-1];
  logic [CW-1:0]   stmr_r;
  logic [7:0]      bank_nxt;
  logic [7:0]      ap_fire;

  wire [3:0] cmd     = {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n};
  wire       live    = mem.cke && cke_q_r && !self_ref;
  wire       is_act  = live && cmd == CMD_ACT;
  wire       is_rd   = live && cmd == CMD_RD;
  wire       is_wr   = live && cmd == CMD_WR;
  wire       is_pre  = live && cmd == CMD_PRE;
  wire       is_ref  = live && cmd == CMD_REF;
  wire       is_sre  = cke_q_r && !mem.cke && !self_ref && cmd == CMD_REF;
  wire       is_srx  = self_ref && mem.cke;
  wire [2:0] al_eff  = (cfg_al > 3'(AL_MAX)) ? 3'(AL_MAX) : cfg_al;
  wire [3:0] half_bl = cfg_bl8 ? 4'h4 : 4'h2;
  wire [4:0] rd_ap   = 5'(al_eff) + 5'(half_bl);
  wire [4:0] wr_ap   = 5'(al_eff) + 5'(cfg_cl) - 5'h1 + 5'(half_bl) + 5'(cfg_wr);
  wire       col_bad = (is_rd || is_wr) && !bank_open[mem.ba];
  wire       act_bad = is_act && bank_open[mem.ba];
  wire [14:0] col_in = {is_rd, is_wr && !is_rd, mem.ba, mem.addr[9:0]};
  wire [14:0] col_out = (al_eff == 3'h0) ? col_in : pipe_r[al_eff - 3'h1];

  // posted column delay line, one stage per cycle of additive latency
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pipe_r[0] <= 15'h0000;
    else if (clk_en) pipe_r[0] <= col_in; // see [RL4]
  end
  genvar g;
  generate
    for (g = 1; g < AL_MAX; g++) begin : g_pipe
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) pipe_r[g] <= 15'h0000;
        else if (clk_en) pipe_r[g] <= pipe_r[g-1];
      end
    end
    // per bank countdown to the auto close of the row
    for (g = 0; g < 8; g++) begin : g_ap
      logic [4:0] cnt_r;
      wire hit = (is_rd || is_wr) && mem.ba == 3'(g) && mem.addr[A_ACLR];
      assign ap_fire[g] = cnt_r == 5'h01;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) cnt_r <= 5'h00;
        else if (clk_en) begin
          if (hit) cnt_r <= is_rd ? rd_ap : wr_ap; // see [RL10] see [RL11]
          else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
        end
      end
    end
  endgenerate

  always_comb begin
    bank_nxt = bank_open & ~ap_fire;
    if (is_act) bank_nxt = bank_nxt | bank_hot(mem.ba); // see [RL3]
    if (is_pre) begin
      if (mem.addr[A_ACLR]) bank_nxt = 8'h00; // see [RL12]
      else bank_nxt = bank_nxt & ~bank_hot(mem.ba);
    end
    if (is_ref) bank_nxt = 8'h00; // see [RL19]
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cke_q_r   <= 1'b0;
      bank_open <= 8'h00;
      self_ref  <= 1'b0;
      dll_on    <= 1'b1;
      col_rd    <= 1'b0;
      col_wr    <= 1'b0;
      col_bank  <= 3'h0;
      col_addr  <= 10'h000;
      rd_lat    <= 4'h0;
      wr_lat    <= 4'h0;
      ref_row   <= 14'h0000;
      stmr_r    <= '0;
      cmd_err   <= 1'b0;
    end else if (clk_en) begin
      cke_q_r   <= mem.cke;
      bank_open <= bank_nxt; // see [RL9] see [RL23]
      col_rd    <= col_out[14] && !col_bad; // see [RL8]
      col_wr    <= col_out[13] && !col_bad;
      col_bank  <= col_out[12:10];
      col_addr  <= col_out[9:0];
      rd_lat    <= 4'(al_eff) + 4'(cfg_cl); // see [RL22]
      wr_lat    <= 4'(al_eff) + 4'(cfg_cl) - 4'h1;
      cmd_err   <= col_bad || act_bad;
      if (is_sre) begin
        self_ref <= 1'b1; // see [RL14]
        dll_on   <= 1'b0;
        stmr_r   <= CW'(REFI_CK - 1);
      end else if (is_srx) begin
        self_ref <= 1'b0;
        dll_on   <= 1'b1;
      end
      if (is_ref) ref_row <= ref_row + 14'h0001; // see [RL19]
      else if (self_ref) begin
        if (stmr_r == '0) begin
          stmr_r  <= CW'(REFI_CK - 1);
          ref_row <= ref_row + 14'h0001;
        end else stmr_r <= stmr_r - 1'b1;
      end
    end
  end
endmodule // ddc_dev

// *** verif/ddc_checker.sv ***
/*
  concurrent checks on the command pins joining the two ddr2 ends.
  assumes one clock, sys_clk, and an active high asynchronous reset.
*/
`timescale 1ns/1ps
module ddc_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        odt,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr
);
  import ddc_pkg::*;
  localparam int GAP_MAX = 9 * REFI_CK;
  wire logic [3:0] cmd_w  = {cs_n, ras_n, cas_n, we_n};
  wire logic       act_w  = cke && (cmd_w == CMD_ACT);
  wire logic       ref_w  = cke && (cmd_w == CMD_REF);
  wire logic       sre_w  = !cke && (cmd_w == CMD_REF);
  wire logic       mrs_w  = cke && (cmd_w == CMD_MRS);
  wire logic       prea_w = cke && (cmd_w == CMD_PRE) && addr[A_ACLR];
  wire logic       nop_w  = cs_n || (cmd_w == CMD_NOP);
  logic            sref_r;
  logic [15:0]     gap_r;
  logic [FAW_HIST-1:0] faw_r;
  wire logic       exit_w = cke && sref_r;

  // self refresh tracking and refresh gap count
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sref_r <= 1'b0;
      gap_r  <= 16'h0000;
      faw_r  <= '0;
    end else begin
      sref_r <= sre_w || (sref_r && !cke);
      faw_r  <= FAW_HIST'({faw_r, act_w});
      gap_r  <= (ref_w || sre_w || sref_r) ? 16'h0000 : gap_r + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_sre_hold; !cke ##1 !cke ##1 !cke; endsequence
  sequence s_exit_nop; nop_w [*6]; endsequence

  property p_aofd; mrs_w |-> !odt && !$past(odt) && !$past(odt, 2) && !$past(odt, 3); endproperty
  property p_mod; mrs_w |=> !odt; endproperty
  property p_rc;
    act_w |=> !(act_w && ba == $past(ba)) ##1 !(act_w && ba == $past(ba, 2));
  endproperty
  property p_prea; prea_w |=> !act_w && !ref_w; endproperty
  property p_sre_odt; sre_w |-> !odt; endproperty
  property p_sre_hold; sre_w |-> s_sre_hold; endproperty
  property p_xsnr; exit_w |-> s_exit_nop; endproperty
  property p_xsrd; exit_w |-> (cke && !odt) [*8]; endproperty
  property p_rfc; ref_w |=> !(act_w || ref_w) [*5]; endproperty
  property p_refi; gap_r <= GAP_MAX; endproperty
  property p_faw; act_w |-> $countones(faw_r) < 4; endproperty

  a_aofd:     assert property (p_aofd) else $error("mode set without odt quiet");
  a_mod:      assert property (p_mod) else $error("odt raised in update window");
  a_rc:       assert property (p_rc) else $error("same bank activates too close");
  a_prea:     assert property (p_prea) else $error("command too soon after prea");
  a_sre_odt:  assert property (p_sre_odt) else $error("odt on at self refresh");
  a_sre_hold: assert property (p_sre_hold) else $error("cke not held low");
  a_xsnr:     assert property (p_xsnr) else $error("command during exit interval");
  a_xsrd:     assert property (p_xsrd) else $error("cke or odt wrong after exit");
  a_rfc:      assert property (p_rfc) else $error("command inside refresh cycle");
  a_refi:     assert property (p_refi) else $error("refresh gap too long");
  a_faw:      assert property (p_faw) else $error("too many activates in window");
endmodule // ddc_checker

// *** verif/ddr2_command_bank_refresh_test.sv ***
/*
  self-checking bench: controller and device joined by ddc_if.
  assumes register map and op codes of ddc_pkg; cfg pins static.
*/
`timescale 1ns/1ps
module ddr2_command_bank_refresh_test;
  import ddc_pkg::*;
  typedef struct packed {
    logic [3:0]  op;
    logic [2:0]  ba;
    logic [13:0] ad;
    logic [7:0]  open;
  } ddc_row_t;
  localparam int CYC_MAX = 6000;
  logic        sys_clk;
  logic        sys_rst;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  bank_open;
  logic        self_ref;
  logic        dll_on;
  logic        col_rd;
  logic        col_wr;
  logic [2:0]  col_bank;
  logic [9:0]  col_addr;
  logic [3:0]  rd_lat;
  logic [3:0]  wr_lat;
  logic [13:0] ref_row;
  logic        cmd_err;
  logic        dev_err;
  logic [14:0] col_seen;
  logic [31:0] s;
  logic [13:0] r0;
  logic        err_seen;
  int          err_total;
  int          cmp_count;
  int          cyc_cnt;
  ddc_row_t    rows [9];

  ddc_if mem_if (.sys_clk(sys_clk));
  ddc_ctl ddc_ctl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem(mem_if.ctl));
  ddc_dev ddc_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .mem(mem_if.dev), .cfg_al(3'h2), .cfg_cl(3'h3), .cfg_bl8(1'b0), .cfg_wr(3'h3),
    .bank_open(bank_open), .self_ref(self_ref), .dll_on(dll_on), .col_rd(col_rd),
    .col_wr(col_wr), .col_bank(col_bank), .col_addr(col_addr), .rd_lat(rd_lat),
    .wr_lat(wr_lat), .ref_row(ref_row), .cmd_err(cmd_err));
  ddc_checker ddc_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cke(mem_if.cke),
    .cs_n(mem_if.cs_n), .ras_n(mem_if.ras_n), .cas_n(mem_if.cas_n), .we_n(mem_if.we_n),
    .odt(mem_if.odt), .ba(mem_if.ba), .addr(mem_if.addr));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // column events captured away from the active edge
  always @(negedge sys_clk) begin
    if (col_rd || col_wr) col_seen = {col_rd, col_wr, col_bank, col_addr};
    if (cmd_err) dev_err = 1'b1;
  end

  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == CYC_MAX) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // issue one order and poll until it leaves the pending slot
  task automatic cmd(input logic [3:0] op, input logic [2:0] ba, input logic ac,
                     input logic [13:0] ad);
    int n;
    err_seen = 1'b0;
    reg_write(REG_CMD, {10'h000, ad, ac, ba, op});
    for (n = 0; n < 300; n++) begin
      reg_read(REG_STAT, s);
      err_seen = err_seen | s[2];
      if (s[0] === 1'b0) break;
    end
    chk(32'(n < 300), 32'h0000_0001);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cyc_cnt = 0;
    col_seen = 15'h0000;
    dev_err = 1'b0;
    clk_en = 1'b1;
    rows = '{'{OP_ACT, 3'h1, 14'h0123, 8'h02}, '{OP_ACT, 3'h5, 14'h0456, 8'h22},
             '{OP_WR, 3'h1, 14'h003a, 8'h22}, '{OP_RD, 3'h5, 14'h0155, 8'h22},
             '{OP_PRE, 3'h1, 14'h0000, 8'h20}, '{OP_PREA, 3'h0, 14'h0000, 8'h00},
             '{OP_ACT, 3'h7, 14'h3fff, 8'h80}, '{OP_PREA, 3'h0, 14'h0000, 8'h00},
             '{OP_REF, 3'h0, 14'h0000, 8'h00}};
    repeat (5) @(posedge sys_clk);
    chk(32'({mem_if.cke, mem_if.cs_n, mem_if.ras_n, mem_if.cas_n, mem_if.we_n}),
        32'h0000_0007);
    chk(32'(dll_on), 32'h0000_0001);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'({rd_lat, wr_lat}), 32'h0000_0054);
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].ba, 1'b0, rows[i].ad);
      repeat (4) @(posedge sys_clk);
      chk(32'(bank_open), 32'(rows[i].open));
      chk(32'(err_seen), 32'h0000_0000);
      if (rows[i].op == OP_RD || rows[i].op == OP_WR)
        chk(32'(col_seen), 32'({rows[i].op == OP_RD, rows[i].op == OP_WR, rows[i].ba,
            rows[i].ad[9:0]}));
    end
    cmd(OP_RD, 3'h2, 1'b0, 14'h0010);
    chk(32'(err_seen), 32'h0000_0001);
    cmd(OP_ACT, 3'h3, 1'b0, 14'h0001);
    cmd(OP_RD, 3'h3, 1'b1, 14'h0010);
    repeat (8) @(posedge sys_clk);
    chk(32'(bank_open), 32'h0000_0000);
    cmd(OP_ACT, 3'h4, 1'b0, 14'h0002);
    cmd(OP_WR, 3'h4, 1'b1, 14'h0020);
    repeat (14) @(posedge sys_clk);
    chk(32'(bank_open), 32'h0000_0000);
    reg_write(REG_CFG, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk(32'(mem_if.odt), 32'h0000_0001);
    cmd(OP_EMRS, 3'h0, 1'b0, 14'h0004);
    repeat (4) @(posedge sys_clk);
    chk(32'(mem_if.odt), 32'h0000_0001);
    cmd(OP_SRE, 3'h0, 1'b0, 14'h0000);
    repeat (3) @(posedge sys_clk);
    chk(32'({self_ref, dll_on, mem_if.odt}), 32'h0000_0004);
    cmd(OP_SRX, 3'h0, 1'b0, 14'h0000);
    repeat (XSNR_CK) @(posedge sys_clk);
    chk(32'({self_ref, dll_on}), 32'h0000_0001);
    reg_read(REG_STAT, s);
    chk(32'(s[3]), 32'h0000_0001);
    cmd(OP_REF, 3'h0, 1'b0, 14'h0000);
    reg_read(REG_STAT, s);
    chk(32'(s[3]), 32'h0000_0000);
    // a write while frozen must not be taken
    @(posedge sys_clk);
    clk_en <= 1'b0;
    reg_write(REG_CMD, {10'h000, 14'h0001, 1'b0, 3'h2, OP_ACT});
    clk_en <= 1'b1;
    reg_read(REG_STAT, s);
    chk(32'(s[15:0]), 32'h0000_0000);
    r0 = ref_row;
    repeat (3 * REFI_CK + 40) @(posedge sys_clk);
    reg_read(REG_STAT, s);
    chk(32'(s[7:4]), 32'h0000_0000);
    chk(32'(ref_row !== r0), 32'h0000_0001);
    chk(32'(dev_err), 32'h0000_0000);
    give_verdict();
  end
endmodule // ddr2_command_bank_refresh_test
